// File: inc/dxw_pkg.sv
// package: offsets, field layout, reset values and carriers of the
// window 1 translation registers and the express capability header.
// assumes a 32-bit avalon slave with word addressing by byte offset.
package dxw_pkg;

  // ------------------------------------------------------------------
  // offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] XBASE_OFS = 8'h0A8;
  localparam logic [7:0] SETUP_OFS = 8'h0AC;
  localparam logic [7:0] CAPHD_OFS = 8'h0B0;
  localparam logic [7:0] MODE_OFS  = 8'h0C0;

  // ------------------------------------------------------------------
  // field layout and values
  // ------------------------------------------------------------------
  localparam int XBASE_LSB   = 6;
  localparam int MASK_MSB    = 30;
  localparam int ENABLE_BIT  = 31;
  localparam int PREF_BIT    = 3;
  localparam logic [31:0] XBASE_RST = 32'h0000_0000;
  localparam logic [31:0] SETUP_RST = 32'h0000_0000;
  localparam logic [31:0] XBASE_WMASK = 32'hFFFF_FFC0;
  localparam logic [31:0] SETUP_WMASK = 32'hFFFF_FFCE;
  localparam logic [1:0]  ADDR32 = 2'h0;
  localparam logic [1:0]  ADDR64 = 2'h1;
  localparam logic [7:0]  CAP_ID   = 8'h10;
  localparam logic [7:0]  NEXT_PTR = 8'hF0;
  localparam logic [3:0]  CAP_VER  = 4'h1;
  localparam logic [3:0]  PORT_FWD = 4'h7;
  localparam logic [3:0]  PORT_REV = 4'h8;
  localparam logic [4:0]  MSG_NUM  = 5'h00;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        enable;
    logic [24:0] sizeMask;
    logic [1:0]  rsvd;
    logic        prefetch;
    logic [1:0]  addrType;
    logic        typeSel;
  } dxw_setup_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [4:0] msgNum;
    logic       slotImpl;
    logic [3:0] portType;
    logic [3:0] version;
    logic [7:0] nextPtr;
    logic [7:0] capId;
  } dxw_caphdr_t;

  typedef enum logic [1:0] {
    DXW_IDLE = 2'b00,
    DXW_ACK  = 2'b01
  } dxw_state_t;

endpackage

// File: logic/dxw_xlate.sv
// translator: replaces masked request address bits with the base.
// assumes request address arrives in the core_clk domain.
`timescale 1ns/1ps
module dxw_xlate (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // window setup
  input  wire logic [31:0] xbase,
  input  wire logic [31:0] setup,
  // request
  input  wire logic        reqValid,
  input  wire logic [31:0] reqAddr,
  // result
  output      logic        outValid,
  output      logic        outHit,
  output      logic [31:0] outAddr
);

  logic [31:0] selMask;
  logic [31:0] next_addr;
  logic        winOn;

  // mask bit 31 tracks bit 30 so the top of the base translates only when bit 30 is set
  assign selMask   = {setup[30], setup[30:6], 6'h00};
  assign winOn     = setup[dxw_pkg::ENABLE_BIT];
  assign next_addr = winOn ? ((reqAddr & ~selMask) | (xbase & selMask))
                           : reqAddr; // [RULE13]

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      outValid <= 1'b0;
      outHit   <= 1'b0;
      outAddr  <= 32'h0000_0000;
    end else begin
      outValid <= reqValid;
      outHit   <= reqValid & winOn;
      outAddr  <= next_addr; // [RULE1]
    end
  end

endmodule // dxw_xlate

// File: logic/dxw_regs.sv
// register bank: window 1 translated base, window 1 setup, capability
// header, plus a bridge mode register; drives the window translator.
// assumes an avalon-mm master on core_clk; byte address on avmAddress.
//
// Functional notes
// [RULE1] writable base bits 31:6 translate requests
// [RULE2] only size-mask bits of base are used
// [RULE3] type selector bit 0 reads zero
// [RULE4] address type 2:1, 00 32-bit, 01 64-bit
// [RULE5] size mask bit makes base bit writable
// [RULE6] software keeps mask bits 11:6 zero
// [RULE7] setup bit 31 enables window, resets 0
// [RULE8] capability id reads 10h
// [RULE9] next pointer reads F0h
// [RULE10] port type 0111 forward, 1000 reverse
// [RULE11] slot implemented 0 forward, 1 reverse
// [RULE12] header reads 0071F010h or 0181F010h
// [RULE13] masked address bits replaced by base
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module dxw_regs (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // avalon-mm slave
  input  wire logic [7:0]  avmAddress,
  input  wire logic        avmRead,
  input  wire logic        avmWrite,
  input  wire logic [3:0]  avmByteEnable,
  input  wire logic [31:0] avmWriteData,
  output      logic [31:0] avmReadData,
  output      logic        avmWaitRequest,
  // downstream request
  input  wire logic        reqValid,
  input  wire logic [31:0] reqAddr,
  // translated request
  output      logic        xlValid,
  output      logic        xlHit,
  output      logic [31:0] xlAddr
);

  // ------------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------------
  // one wait state per access: answer at the second edge of a request
  dxw_pkg::dxw_state_t state;
  dxw_pkg::dxw_state_t next_state;
  logic                access;
  logic                doWrite;
  logic                doRead;

  assign access     = avmRead | avmWrite;
  assign next_state = (state == dxw_pkg::DXW_IDLE && access)
                      ? dxw_pkg::DXW_ACK : dxw_pkg::DXW_IDLE;
  assign avmWaitRequest = access & (state == dxw_pkg::DXW_IDLE);
  assign doWrite    = avmWrite & (state == dxw_pkg::DXW_ACK);
  assign doRead     = avmRead & (state == dxw_pkg::DXW_ACK);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= dxw_pkg::DXW_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  logic        hitXbase;
  logic        hitSetup;
  logic        hitCap;
  logic        hitMode;
  logic [31:0] byteMask;

  assign hitXbase = avmAddress == dxw_pkg::XBASE_OFS;
  assign hitSetup = avmAddress == dxw_pkg::SETUP_OFS;
  assign hitCap   = avmAddress == dxw_pkg::CAPHD_OFS;
  assign hitMode  = avmAddress == dxw_pkg::MODE_OFS;
  assign byteMask = {{8{avmByteEnable[3]}}, {8{avmByteEnable[2]}},
                     {8{avmByteEnable[1]}}, {8{avmByteEnable[0]}}};

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [31:0]          xbase;
  dxw_pkg::dxw_setup_t  setup;
  logic                 reverseMode;
  logic [31:0]          xbaseWritable;
  logic [31:0]          wrBits;
  logic [31:0]          next_xbase;
  logic [31:0]          next_setup;
  logic [31:0]          setupWord;

  // mask bit 31 follows bit 30 so the top base bit stays with the size
  assign xbaseWritable = dxw_pkg::XBASE_WMASK &
                         {setup.sizeMask[24], setup.sizeMask, 6'h00}; // [RULE5]
  assign wrBits     = byteMask & xbaseWritable;
  assign next_xbase = (xbase & ~wrBits) | (avmWriteData & wrBits); // [RULE2]
  assign setupWord  = setup;
  // setup is preset by configuration software through this port;
  // type selector and reserved bits are never writable
  assign next_setup = (setupWord & ~(byteMask & dxw_pkg::SETUP_WMASK)) |
                      (avmWriteData & byteMask & dxw_pkg::SETUP_WMASK); // [RULE4]

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      xbase <= dxw_pkg::XBASE_RST;
    end else if (doWrite && hitXbase) begin
      xbase <= next_xbase; // [RULE1]
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      setup <= dxw_pkg::SETUP_RST; // [RULE7]
    end else if (doWrite && hitSetup) begin
      setup <= next_setup; // [RULE3]
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reverseMode <= 1'b0;
    end else if (doWrite && hitMode && avmByteEnable[0]) begin
      reverseMode <= avmWriteData[0];
    end
  end

  // ------------------------------------------------------------------
  // capability header
  // ------------------------------------------------------------------
  dxw_pkg::dxw_caphdr_t capHdr;

  assign capHdr.capId    = dxw_pkg::CAP_ID; // [RULE8]
  assign capHdr.nextPtr  = dxw_pkg::NEXT_PTR; // [RULE9]
  assign capHdr.version  = dxw_pkg::CAP_VER;
  assign capHdr.portType = reverseMode ? dxw_pkg::PORT_REV
                                       : dxw_pkg::PORT_FWD; // [RULE10]
  assign capHdr.slotImpl = reverseMode; // [RULE11]
  assign capHdr.msgNum   = dxw_pkg::MSG_NUM; // [RULE12]
  assign capHdr.rsvd     = 2'h0;

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  logic [31:0] rdSel;
  logic [31:0] next_rdata;

  assign rdSel = hitXbase ? xbase :
                 hitSetup ? setupWord :
                 hitCap   ? capHdr :
                 hitMode  ? {31'h0000_0000, reverseMode} :
                            32'h0000_0000;
  assign next_rdata = doRead ? rdSel : avmReadData;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      avmReadData <= 32'h0000_0000;
    end else if (next_state == dxw_pkg::DXW_ACK && avmRead) begin
      avmReadData <= rdSel;
    end else begin
      avmReadData <= next_rdata;
    end
  end

  // ------------------------------------------------------------------
  // translation
  // ------------------------------------------------------------------
  dxw_xlate u_xlate (
    .core_clk (core_clk),
    .rstn     (rstn),
    .xbase    (xbase),
    .setup    (setupWord),
    .reqValid (reqValid),
    .reqAddr  (reqAddr),
    .outValid (xlValid),
    .outHit   (xlHit),
    .outAddr  (xlAddr)
  ); // [RULE2]

endmodule // dxw_regs

// File: testbench/dxw_regs_props.sv
// checker: fixed fields and translation timing of dxw_regs.
// assumes it is bound onto dxw_regs and sees its ports only.
`timescale 1ns/1ps
module dxw_regs_props (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // bus
  input wire logic [7:0]  avmAddress,
  input wire logic        avmRead,
  input wire logic [31:0] avmReadData,
  input wire logic        avmWaitRequest,
  // translation
  input wire logic        reqValid,
  input wire logic [31:0] reqAddr,
  input wire logic        xlValid,
  input wire logic        xlHit,
  input wire logic [31:0] xlAddr
);
  // read data stands in the cycle waitrequest drops
  wire rdEnd  = avmRead && !avmWaitRequest;
  wire rdBase = rdEnd && avmAddress == 8'hA8;
  wire rdSet  = rdEnd && avmAddress == 8'hAC;
  wire rdCap  = rdEnd && avmAddress == 8'hB0;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ----------
  // properties
  // ----------
  property p_base; rdBase |-> avmReadData[5:0] == 6'h00; endproperty
  a_base: assert property (p_base) else $error("base low bits");
  property p_type; rdSet |-> !avmReadData[0]; endproperty
  a_type: assert property (p_type) else $error("type bit");
  property p_id; rdCap |-> avmReadData[7:0] == 8'h10; endproperty
  a_id: assert property (p_id) else $error("cap id");
  property p_next; rdCap |-> avmReadData[15:8] == 8'hF0; endproperty
  a_next: assert property (p_next) else $error("next ptr");
  property p_port;
    rdCap |-> avmReadData[24:20] inside {5'h07, 5'h18};
  endproperty
  a_port: assert property (p_port) else $error("port type");
  property p_val; reqValid |=> xlValid; endproperty
  a_val: assert property (p_val) else $error("no result");
  property p_pass;
    xlValid && !xlHit |-> xlAddr == $past(reqAddr);
  endproperty
  a_pass: assert property (p_pass) else $error("miss altered");
  property p_off;
    xlValid |-> xlAddr[5:0] == $past(reqAddr[5:0]);
  endproperty
  a_off: assert property (p_off) else $error("offset altered");
endmodule // dxw_regs_props
bind dxw_regs dxw_regs_props i_dxw_regs_props (.*);

// File: testbench/test_downstream_xlate_window_and_cap_hdr.sv
// bench: reset values, fixed fields, masking, translation, mode.
// assumes dxw_pkg is compiled first and the checker binds itself.
`timescale 1ns/1ps
module test_downstream_xlate_window_and_cap_hdr;
  logic        core_clk = 1'h0, rstn = 1'h0, avmRead = 1'h0;
  logic        avmWrite = 1'h0, reqValid = 1'h0, avmWaitRequest;
  logic        xlValid, xlHit;
  logic [7:0]  avmAddress = 8'h00;
  logic [31:0] avmWriteData = 32'h0000_0000, reqAddr = 32'h0000_0000;
  logic [31:0] avmReadData, xlAddr;
  int          err_total = 0, tests_run = 0, cyc = 0;
  dxw_regs i_dxw_regs (.*, .avmByteEnable(4'hF));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 400) err_total++;
    if (cyc == 400) test_done();
  end
  // -----
  // tasks
  // -----
  task test_done();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) err_total++;
    if (got !== exp) $display("unexpected %0t %h %h", $time, got, exp);
  endtask
  // v is write data, or the expected word of a read
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    avmAddress <= a;
    avmWrite <= w;
    avmRead <= !w;
    avmWriteData <= v;
    do @(posedge core_clk); while (avmWaitRequest !== 1'h0);
    if (!w) chk(avmReadData, v);
    avmRead <= 1'h0;
    avmWrite <= 1'h0;
    // idle edge: a strobe never rises in the step it fell
    @(posedge core_clk);
  endtask
  task req(input logic [31:0] a, input logic hit, input logic [31:0] e);
    reqAddr <= a;
    reqValid <= 1'h1;
    @(posedge core_clk);
    reqValid <= 1'h0;
    // let the result register land before looking
    #1;
    chk({xlValid, xlHit, 30'h0}, {1'h1, hit, 30'h0});
    chk(xlAddr, e);
    @(posedge core_clk);
  endtask
  task t_reset();
    bus(1'h0, 8'hA8, 32'h0000_0000);
    bus(1'h0, 8'hAC, 32'h0000_0000);
    bus(1'h0, 8'hB0, 32'h0071_F010);
    bus(1'h0, 8'h04, 32'h0000_0000);
  endtask
  task t_xlate();
    bus(1'h1, 8'hB0, 32'hFFFF_FFFF);
    bus(1'h0, 8'hB0, 32'h0071_F010);
    bus(1'h1, 8'hAC, 32'h8000_F002);
    bus(1'h0, 8'hAC, 32'h8000_F002);
    bus(1'h1, 8'hA8, 32'hFFFF_FFFF);
    bus(1'h0, 8'hA8, 32'h0000_F000);
    req(32'h1234_5678, 1'h1, 32'h1234_F678);
    bus(1'h1, 8'hAC, 32'h0000_0000);
    req(32'h1234_5678, 1'h0, 32'h1234_5678);
  endtask
  task t_mode();
    bus(1'h1, 8'hC0, 32'h0000_0001);
    bus(1'h0, 8'hB0, 32'h0181_F010);
    bus(1'h1, 8'hC0, 32'h0000_0000);
    bus(1'h0, 8'hB0, 32'h0071_F010);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    t_reset();
    t_xlate();
    t_mode();
    test_done();
  end
endmodule // test_downstream_xlate_window_and_cap_hdr
